// file: fdcrd_defines.vh
`ifndef FDCRD_DEFINES_VH
`define FDCRD_DEFINES_VH

// register indices
`define FDCRD_OFS_STATUS   4'h0
`define FDCRD_OFS_DATA     4'h1
`define FDCRD_OFS_CONFIG   4'h2
`define FDCRD_OFS_PRECOMP  4'h3
`define FDCRD_OFS_STEP     4'h4
`define FDCRD_OFS_PERP     4'h5
`define FDCRD_OFS_CYL      4'h6
`define FDCRD_OFS_SECTORS  4'h7
`define FDCRD_OFS_STAT3    4'h8

// config bit positions
`define FDCRD_CFG_POLLDIS  0
`define FDCRD_CFG_WRITE_GATE_TIMING    1
`define FDCRD_CFG_OWPERMIT 2
`define FDCRD_CFG_VERIFYEC 3
`define FDCRD_CFG_NONDMA   4

// command byte fields
`define FDCRD_OP_MT        7
`define FDCRD_OP_DD        6
`define FDCRD_OP_SKIP      5
`define FDCRD_OP_READ      5'h06
`define FDCRD_OP_READDEL   5'h0C

// status values
`define FDCRD_ST0_INVALID  8'h80
`define FDCRD_ST2_DELMARK  8'h40
`define FDCRD_RESET_VAL    8'h00
`define FDCRD_CMD_LAST     4'h8
`define FDCRD_RES_LAST     3'h6

// phases
`define FDCRD_PH_IDLE      2'h0
`define FDCRD_PH_CMD       2'h1
`define FDCRD_PH_EXEC      2'h2
`define FDCRD_PH_RES       2'h3

// timing
`define FDCRD_CLK_NS       10
`define FDCRD_STEP_UNIT_NS 500000
`define FDCRD_STEP_UNITS   5'h10

`endif

// file: fdcrd_core.v
// Notes on behaviour
// - cylinder register read returns head position when sense completes.
// - poll disable bit set stops drive polling; clear keeps it running.
// - precompensation start track accepts every value 00 to FF.
// - supplied sector number is the first sector; transfer advances from it.
// - relative seek offset steps from the present cylinder, signed.
// - sectors-per-track sets format count and verify count when enabled.
// - skip flag in read data skips sectors with deleted mark.
// - read deleted touches only sectors carrying the deleted mark.
// - step interval 0.5 ms to 8 ms in 0.5 ms steps.
// - status zero, one and two hold completion info, read in result phase; status three is read at its own register.
// - write gate timing setting shifts write enable for pre-erase.
// - perpendicular low four bits change only when overwrite permit is one.
// - after command bytes an execution phase moves sector data.
// - result gives status zero, one, two, then C H R N.
// - multi track continues from last sector head 0 to sector 1 head 1.
// - double density flag selects double or single density encoding.
// - size code 0 uses data length limit, else 128 shifted by code.
// - non dma flag interrupts per byte, else dma request per byte.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "fdcrd_defines.vh"

module fdcrd_core #(
	parameter STEP_UNIT = `FDCRD_STEP_UNIT_NS / `FDCRD_CLK_NS
) (
	// clock and reset
	input  wire        core_clk,
	input  wire        rst,
	// register port
	input  wire [3:0]  regAddr,
	input  wire [7:0]  regWdata,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [7:0]  regRdata,
	// drive side
	input  wire        driveSectorStart,
	input  wire        driveSectorDeleted,
	input  wire        driveByteValid,
	input  wire [7:0]  driveByte,
	input  wire        senseDone,
	output reg         stepPulse,
	output reg         stepDirOut,
	output reg         doubleDensity,
	output reg         headSelect,
	output reg  [1:0]  driveSelect,
	output reg         pollEnable,
	output reg         precompActive,
	output reg         writeGateEarly,
	output reg  [3:0]  perpMode,
	output reg  [7:0]  formatSectorCount,
	output reg  [7:0]  verifySectorCount,
	// system side
	output reg  [7:0]  xferByte,
	output reg         dmaReq,
	output reg         xferIrq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [1:0]  phase_reg;
	reg [3:0]  cmdIdx_reg;
	reg [2:0]  resIdx_reg;
	reg [2:0]  resLast_reg;
	reg [7:0]  opcode_reg;
	reg [7:0]  cyl_reg;
	reg [7:0]  head_reg;
	reg [7:0]  sector_reg;
	reg [7:0]  sizeCode_reg;
	reg [7:0]  finalSector_reg;
	reg [7:0]  gapLength_reg;
	reg [7:0]  dataLimit_reg;
	reg [7:0]  status0_reg;
	reg [7:0]  status1_reg;
	reg [7:0]  status2_reg;
	reg [7:0]  status3_reg;
	reg [7:0]  config_reg;
	reg [7:0]  precomp_reg;
	reg [3:0]  stepRate_reg;
	reg [7:0]  presentCyl_reg;
	reg [7:0]  senseCyl_reg;
	reg [7:0]  sectorsPerTrack_reg;
	reg [7:0]  seekLeft_reg;
	reg [31:0] stepCnt_reg;
	reg [14:0] byteCnt_reg;
	reg        secActive_reg;
	reg        secSkip_reg;

	wire [4:0]  opKind = opcode_reg[4:0];
	wire        isReadDel = (opKind == `FDCRD_OP_READDEL);
	wire [14:0] sectorBytes = (sizeCode_reg[2:0] == 3'h0) ?
		{7'h00, dataLimit_reg} : (15'h0080 << sizeCode_reg[2:0]);
	wire        hostWrData = regWr && (regAddr == `FDCRD_OFS_DATA);
	wire        hostRdData = regRd && (regAddr == `FDCRD_OFS_DATA);
	wire        lastSector = (sector_reg == finalSector_reg);
	wire        mtWrap = opcode_reg[`FDCRD_OP_MT] && (head_reg[0] == 1'b0);
	wire [31:0] stepPeriod = STEP_UNIT *
		({27'h0, `FDCRD_STEP_UNITS} - {28'h0, stepRate_reg});

	// ----------------------------------------------------------------
	// result byte select
	// ----------------------------------------------------------------
	reg [7:0] resByte;
	always @*
	begin
		case (resIdx_reg)
			3'h0: resByte = status0_reg;
			3'h1: resByte = status1_reg;
			3'h2: resByte = status2_reg;
			3'h3: resByte = cyl_reg;
			3'h4: resByte = head_reg;
			3'h5: resByte = sector_reg;
			3'h6: resByte = sizeCode_reg;
			default: resByte = `FDCRD_RESET_VAL;
		endcase
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	reg [7:0] rdMux;
	always @*
	begin
		case (regAddr)
			`FDCRD_OFS_STATUS:  rdMux = {4'h0, secActive_reg,
				(seekLeft_reg != 8'h00), phase_reg};
			`FDCRD_OFS_DATA:    rdMux = (phase_reg == `FDCRD_PH_RES) ?
				resByte : `FDCRD_RESET_VAL;
			`FDCRD_OFS_CONFIG:  rdMux = config_reg;
			`FDCRD_OFS_PRECOMP: rdMux = precomp_reg;
			`FDCRD_OFS_STEP:    rdMux = {4'h0, stepRate_reg};
			`FDCRD_OFS_PERP:    rdMux = {4'h0, perpMode};
			`FDCRD_OFS_CYL:     rdMux = senseCyl_reg;
			`FDCRD_OFS_SECTORS: rdMux = sectorsPerTrack_reg;
			`FDCRD_OFS_STAT3:   rdMux = status3_reg;
			default:            rdMux = `FDCRD_RESET_VAL;
		endcase
	end

	always @(posedge core_clk)
	begin
		if (rst)
			regRdata <= `FDCRD_RESET_VAL;
		else if (regRd)
			regRdata <= rdMux;
		else
			regRdata <= `FDCRD_RESET_VAL;
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			config_reg <= `FDCRD_RESET_VAL;
			precomp_reg <= `FDCRD_RESET_VAL;
			stepRate_reg <= 4'h0;
			perpMode <= 4'h0;
			sectorsPerTrack_reg <= `FDCRD_RESET_VAL;
		end
		else if (regWr)
		begin
			case (regAddr)
				`FDCRD_OFS_CONFIG:  config_reg <= regWdata;
				`FDCRD_OFS_PRECOMP: precomp_reg <= regWdata;
				`FDCRD_OFS_STEP:    stepRate_reg <= regWdata[3:0];
				`FDCRD_OFS_PERP:
					if (config_reg[`FDCRD_CFG_OWPERMIT])
						perpMode <= regWdata[3:0];
				`FDCRD_OFS_SECTORS: sectorsPerTrack_reg <= regWdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// drive control outputs
	// ----------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			pollEnable <= 1'b0;
			precompActive <= 1'b0;
			writeGateEarly <= 1'b0;
			formatSectorCount <= `FDCRD_RESET_VAL;
			verifySectorCount <= `FDCRD_RESET_VAL;
			status3_reg <= `FDCRD_RESET_VAL;
			senseCyl_reg <= `FDCRD_RESET_VAL;
		end
		else
		begin
			pollEnable <= ~config_reg[`FDCRD_CFG_POLLDIS];
			precompActive <= (presentCyl_reg >= precomp_reg);
			writeGateEarly <= config_reg[`FDCRD_CFG_WRITE_GATE_TIMING];
			formatSectorCount <= sectorsPerTrack_reg;
			verifySectorCount <= config_reg[`FDCRD_CFG_VERIFYEC] ?
				sectorsPerTrack_reg : `FDCRD_RESET_VAL;
			status3_reg <= {3'h0, seekLeft_reg == 8'h00,
				presentCyl_reg == 8'h00, headSelect, driveSelect};
			if (senseDone)
				senseCyl_reg <= presentCyl_reg;
		end
	end

	// ----------------------------------------------------------------
	// relative seek and step timing
	// ----------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			presentCyl_reg <= `FDCRD_RESET_VAL;
			seekLeft_reg <= `FDCRD_RESET_VAL;
			stepCnt_reg <= 32'h0000_0000;
			stepPulse <= 1'b0;
			stepDirOut <= 1'b0;
		end
		else
		begin
			stepPulse <= 1'b0;
			if (regWr && regAddr == `FDCRD_OFS_CYL)
			begin
				// signed offset from where the head is now
				stepDirOut <= ~regWdata[7];
				seekLeft_reg <= regWdata[7] ?
					(8'h00 - regWdata) : regWdata;
				stepCnt_reg <= 32'h0000_0000;
			end
			else if (seekLeft_reg != 8'h00)
			begin
				if (stepCnt_reg == 32'h0000_0000)
				begin
					stepPulse <= 1'b1;
					stepCnt_reg <= stepPeriod - 32'h0000_0001;
					seekLeft_reg <= seekLeft_reg - 8'h01;
					presentCyl_reg <= stepDirOut ?
						(presentCyl_reg + 8'h01) :
						(presentCyl_reg - 8'h01);
				end
				else
					stepCnt_reg <= stepCnt_reg - 32'h0000_0001;
			end
			else
				stepCnt_reg <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// command, execution and result phases
	// ----------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			phase_reg <= `FDCRD_PH_IDLE;
			cmdIdx_reg <= 4'h0;
			resIdx_reg <= 3'h0;
			resLast_reg <= 3'h0;
			opcode_reg <= `FDCRD_RESET_VAL;
			cyl_reg <= `FDCRD_RESET_VAL;
			head_reg <= `FDCRD_RESET_VAL;
			sector_reg <= `FDCRD_RESET_VAL;
			sizeCode_reg <= `FDCRD_RESET_VAL;
			finalSector_reg <= `FDCRD_RESET_VAL;
			gapLength_reg <= `FDCRD_RESET_VAL;
			dataLimit_reg <= `FDCRD_RESET_VAL;
			status0_reg <= `FDCRD_RESET_VAL;
			status1_reg <= `FDCRD_RESET_VAL;
			status2_reg <= `FDCRD_RESET_VAL;
			byteCnt_reg <= 15'h0000;
			secActive_reg <= 1'b0;
			secSkip_reg <= 1'b0;
			doubleDensity <= 1'b0;
			headSelect <= 1'b0;
			driveSelect <= 2'h0;
			xferByte <= `FDCRD_RESET_VAL;
			dmaReq <= 1'b0;
			xferIrq <= 1'b0;
		end
		else
		begin
			dmaReq <= 1'b0;
			xferIrq <= 1'b0;
			case (phase_reg)
				`FDCRD_PH_IDLE:
					if (hostWrData)
					begin
						opcode_reg <= regWdata;
						doubleDensity <= regWdata[`FDCRD_OP_DD];
						if (regWdata[4:0] == `FDCRD_OP_READ ||
							regWdata[4:0] == `FDCRD_OP_READDEL)
						begin
							phase_reg <= `FDCRD_PH_CMD;
							cmdIdx_reg <= 4'h1;
						end
						else
						begin
							status0_reg <= `FDCRD_ST0_INVALID;
							resIdx_reg <= 3'h0;
							resLast_reg <= 3'h0;
							phase_reg <= `FDCRD_PH_RES;
						end
					end
				`FDCRD_PH_CMD:
					if (hostWrData)
					begin
						case (cmdIdx_reg)
							4'h1:
							begin
								headSelect <= regWdata[2];
								driveSelect <= regWdata[1:0];
							end
							4'h2: cyl_reg <= regWdata;
							4'h3: head_reg <= regWdata;
							4'h4: sector_reg <= regWdata;
							4'h5: sizeCode_reg <= regWdata;
							4'h6: finalSector_reg <= regWdata;
							4'h7: gapLength_reg <= regWdata;
							default: dataLimit_reg <= regWdata;
						endcase
						cmdIdx_reg <= cmdIdx_reg + 4'h1;
						if (cmdIdx_reg == `FDCRD_CMD_LAST)
						begin
							phase_reg <= `FDCRD_PH_EXEC;
							status0_reg <= {5'h00, headSelect, driveSelect};
							status1_reg <= `FDCRD_RESET_VAL;
							status2_reg <= `FDCRD_RESET_VAL;
							secActive_reg <= 1'b0;
						end
					end
				`FDCRD_PH_EXEC:
					if (driveSectorStart)
					begin
						secActive_reg <= 1'b1;
						byteCnt_reg <= sectorBytes;
						if (isReadDel)
							secSkip_reg <= ~driveSectorDeleted;
						else
						begin
							secSkip_reg <= opcode_reg[`FDCRD_OP_SKIP] &
								driveSectorDeleted;
							if (driveSectorDeleted &&
								!opcode_reg[`FDCRD_OP_SKIP])
								status2_reg <= `FDCRD_ST2_DELMARK;
						end
					end
					else if (secActive_reg && driveByteValid)
					begin
						if (!secSkip_reg)
						begin
							xferByte <= driveByte;
							if (config_reg[`FDCRD_CFG_NONDMA])
								xferIrq <= 1'b1;
							else
								dmaReq <= 1'b1;
						end
						byteCnt_reg <= byteCnt_reg - 15'h0001;
						if (byteCnt_reg == 15'h0001)
						begin
							secActive_reg <= 1'b0;
							if (!lastSector)
								sector_reg <= sector_reg + 8'h01;
							else if (mtWrap)
							begin
								head_reg <= head_reg + 8'h01;
								headSelect <= 1'b1;
								status0_reg[2] <= 1'b1;
								sector_reg <= 8'h01;
							end
							else
							begin
								sector_reg <= sector_reg + 8'h01;
								resIdx_reg <= 3'h0;
								resLast_reg <= `FDCRD_RES_LAST;
								phase_reg <= `FDCRD_PH_RES;
							end
						end
					end
				`FDCRD_PH_RES:
					if (hostRdData)
					begin
						resIdx_reg <= resIdx_reg + 3'h1;
						if (resIdx_reg == resLast_reg)
						begin
							resIdx_reg <= 3'h0;
							phase_reg <= `FDCRD_PH_IDLE;
						end
					end
				default: phase_reg <= `FDCRD_PH_IDLE;
			endcase
		end
	end

endmodule // fdcrd_core

// file: fdcrd_core_sva.sv
`timescale 1ns/100ps
module fdcrd_core_sva (
	// clock and reset
	input wire       core_clk,
	input wire       rst,
	// register port
	input wire [3:0] regAddr,
	input wire [7:0] regWdata,
	input wire       regWr,
	input wire       regRd,
	input wire [7:0] regRdata,
	// drive side
	input wire       driveByteValid,
	input wire [7:0] driveByte,
	input wire       stepPulse,
	input wire       pollEnable,
	input wire       writeGateEarly,
	input wire [3:0] perpMode,
	input wire [7:0] formatSectorCount,
	// system side
	input wire [7:0] xferByte,
	input wire       dmaReq,
	input wire       xferIrq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	wire cfgWr = regWr && regAddr == 4'h2;
	wire perpWr = regWr && regAddr == 4'h5;
	wire xfer = dmaReq || xferIrq;
	sequence stepGap;
		!stepPulse [*3];
	endsequence
	poll_disable_a: assert property (
		cfgWr |-> ##2 pollEnable == !$past(regWdata[0], 2))
		else $error("poll enable wrong");
	write_gate_a: assert property (
		cfgWr |-> ##2 writeGateEarly == $past(regWdata[1], 2))
		else $error("write gate wrong");
	format_count_a: assert property (
		regWr && regAddr == 4'h7 |->
		##2 formatSectorCount == $past(regWdata, 2))
		else $error("sector count wrong");
	perp_guard_a: assert property (
		$changed(perpMode) |-> $past(perpWr) || $past(perpWr, 2))
		else $error("perp bits changed unasked");
	xfer_source_a: assert property (
		xfer |-> $past(driveByteValid) && xferByte == $past(driveByte))
		else $error("forwarded byte wrong");
	xfer_mode_a: assert property (!(dmaReq && xferIrq))
		else $error("dma and irq together");
	step_gap_a: assert property (stepPulse |=> stepGap)
		else $error("step pulses too close");
	read_idle_a: assert property (
		!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data outside slot");
endmodule // fdcrd_core_sva

bind fdcrd_core fdcrd_core_sva i_fdcrd_core_sva (
	.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
	.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .driveByteValid(driveByteValid),
	.driveByte(driveByte), .stepPulse(stepPulse),
	.pollEnable(pollEnable), .writeGateEarly(writeGateEarly),
	.perpMode(perpMode), .formatSectorCount(formatSectorCount),
	.xferByte(xferByte), .dmaReq(dmaReq), .xferIrq(xferIrq));

// file: fdcrd_drive_model.sv
`timescale 1ns/100ps
module fdcrd_drive_model (
	// clock and bench control
	input wire       core_clk,
	input wire       go,
	input wire [1:0] nSec,
	input wire [1:0] delMask,
	// drive lines
	output reg       driveSectorStart,
	output reg       driveSectorDeleted,
	output reg       driveByteValid,
	output reg [7:0] driveByte
);
	integer s, b;
	// sectors of four bytes, one byte every second cycle
	initial
	begin
		driveSectorStart = 1'b0;
		driveSectorDeleted = 1'b0;
		driveByteValid = 1'b0;
		driveByte = 8'h00;
		forever
		begin
			@(posedge core_clk);
			if (go)
				for (s = 0; s < nSec; s = s + 1)
				begin
					driveSectorStart <= 1'b1;
					driveSectorDeleted <= delMask[s];
					@(posedge core_clk);
					driveSectorStart <= 1'b0;
					for (b = 0; b < 4; b = b + 1)
					begin
						@(posedge core_clk);
						driveByteValid <= 1'b1;
						driveByte <= 8'hA0 + s * 4 + b;
						@(posedge core_clk);
						driveByteValid <= 1'b0;
						driveByte <= ~driveByte;
					end
				end
		end
	end
endmodule // fdcrd_drive_model

// file: fdcrd_core_tb.sv
`timescale 1ns/100ps
module fdcrd_core_tb;
	reg         core_clk = 1'b0;
	reg         rst = 1'b1;
	reg  [3:0]  regAddr = 4'h0;
	reg  [7:0]  regWdata = 8'h00;
	reg         regWr = 1'b0;
	reg         regRd = 1'b0;
	reg         senseDone = 1'b0;
	reg         go = 1'b0;
	reg  [1:0]  nSec = 2'h0;
	reg  [1:0]  delMask = 2'h0;
	reg  [7:0]  rv;
	reg  [71:0] cb;
	wire [7:0]  regRdata, driveByte, xferByte, fmtCnt, verCnt;
	wire [3:0]  perpMode;
	wire [1:0]  driveSelect;
	wire        dss, dsd, dbv, stepPulse, stepDirOut, dd, hs;
	wire        pollEnable, precompActive, wgEarly, dmaReq, xferIrq;
	integer     miscompares = 0, n_checks = 0;
	integer     nDma = 0, nIrq = 0, nStep = 0, k;

	fdcrd_core #(.STEP_UNIT(4)) i_fdcrd_core (.core_clk(core_clk),
		.rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .driveSectorStart(dss),
		.driveSectorDeleted(dsd), .driveByteValid(dbv),
		.driveByte(driveByte), .senseDone(senseDone),
		.stepPulse(stepPulse), .stepDirOut(stepDirOut),
		.doubleDensity(dd), .headSelect(hs), .driveSelect(driveSelect),
		.pollEnable(pollEnable), .precompActive(precompActive),
		.writeGateEarly(wgEarly), .perpMode(perpMode),
		.formatSectorCount(fmtCnt), .verifySectorCount(verCnt),
		.xferByte(xferByte), .dmaReq(dmaReq), .xferIrq(xferIrq));
	fdcrd_drive_model i_fdcrd_drive_model (.core_clk(core_clk), .go(go),
		.nSec(nSec), .delMask(delMask), .driveSectorStart(dss),
		.driveSectorDeleted(dsd), .driveByteValid(dbv),
		.driveByte(driveByte));

	initial
	begin
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		nDma = nDma + (dmaReq === 1'b1);
		nIrq = nIrq + (xferIrq === 1'b1);
		nStep = nStep + (stepPulse === 1'b1);
	end

	// ---------
	// bus tasks
	// ---------
	task wr(input [3:0] a, input [7:0] d);
	begin
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
		@(posedge core_clk);
	end
	endtask
	task rd(input [3:0] a, output [7:0] d);
	begin
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
		@(posedge core_clk);
	end
	endtask
	task chk(input [95:0] n, input [7:0] e, input [7:0] g);
	begin
		n_checks = n_checks + 1;
		if (g !== e)
		begin
			miscompares = miscompares + 1;
			$display("ERROR %0s expected %h seen %h", n, e, g);
		end
	end
	endtask
	task rdChk(input [3:0] a, input [7:0] e);
	begin
		rd(a, rv);
		chk("regRdata", e, rv);
	end
	endtask
	task settle;
	begin
		repeat (2) @(posedge core_clk);
		#1;
	end
	endtask
	task seek(input [7:0] off, input integer cyc, input [7:0] n);
	begin
		nStep = 0;
		wr(4'h6, off);
		repeat (cyc) @(posedge core_clk);
		chk("steps", n, nStep[7:0]);
	end
	endtask
	task cmd(input [7:0] op, cfg, hd, final_sector, input [1:0] ns, dm,
		input [7:0] nx, st0, st2, r);
	begin
		wr(4'h2, cfg);
		nDma = 0;
		nIrq = 0;
		cb = {op, hd, 8'h02, 8'h00, 8'h01, 8'h00, final_sector, 8'h1B, 8'h04};
		for (k = 8; k >= 0; k = k - 1)
			wr(4'h1, cb[k*8+:8]);
		nSec <= ns;
		delMask <= dm;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		rv = 8'h00;
		for (k = 0; k < 200 && rv[1:0] !== 2'h3; k = k + 1)
			rd(4'h0, rv);
		chk("phase", 8'h03, rv);
		chk("dma", cfg[4] ? 8'h00 : nx, nDma[7:0]);
		chk("irq", cfg[4] ? nx : 8'h00, nIrq[7:0]);
		chk("dd", {7'h00, op[6]}, {7'h00, dd});
		chk("ds", hd[1:0], {6'h00, driveSelect});
		chk("hs", st0[2], {7'h00, hs});
		cb = {st0, 8'h00, st2, 8'h02, 7'h00, st0[2], r, 8'h00, 16'h0000};
		for (k = 8; k >= 2; k = k - 1)
			rdChk(4'h1, cb[k*8+:8]);
		rdChk(4'h0, 8'h00);
	end
	endtask
	task summarize;
	begin
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask

	// ---------
	// tests
	// ---------
	initial
	begin
		#200000;
		miscompares = miscompares + 1;
		summarize;
	end
	initial
	begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rdChk(4'h0, 8'h00);
		rdChk(4'hF, 8'h00);
		rdChk(4'h1, 8'h00);
		wr(4'h2, 8'h01);
		settle;
		chk("poll", 8'h00, {7'h00, pollEnable});
		wr(4'h2, 8'h02);
		settle;
		chk("poll", 8'h01, {7'h00, pollEnable});
		chk("write_gate_timing", 8'h01, {7'h00, wgEarly});
		wr(4'h3, 8'hFF);
		settle;
		chk("precomp", 8'h00, {7'h00, precompActive});
		rdChk(4'h3, 8'hFF);
		wr(4'h3, 8'h00);
		wr(4'h7, 8'h09);
		settle;
		chk("precomp", 8'h01, {7'h00, precompActive});
		chk("verify", 8'h00, verCnt);
		wr(4'h2, 8'h08);
		wr(4'h5, 8'h0A);
		settle;
		chk("format", 8'h09, fmtCnt);
		chk("verify", 8'h09, verCnt);
		chk("perp", 8'h00, {4'h0, perpMode});
		wr(4'h2, 8'h04);
		wr(4'h5, 8'h0A);
		settle;
		chk("perp", 8'h0A, {4'h0, perpMode});
		wr(4'h4, 8'h0F);
		seek(8'h03, 20, 8'h03);
		chk("dir", 8'h01, {7'h00, stepDirOut});
		seek(8'hFF, 20, 8'h01);
		chk("dir", 8'h00, {7'h00, stepDirOut});
		wr(4'h4, 8'h00);
		seek(8'h02, 60, 8'h01);
		repeat (10) @(posedge core_clk);
		chk("steps", 8'h02, nStep[7:0]);
		senseDone <= 1'b1;
		@(posedge core_clk);
		senseDone <= 1'b0;
		@(posedge core_clk);
		rdChk(4'h6, 8'h04);
		cmd(8'h46, 8'h00, 8'h01, 8'h02, 2, 2'b10, 8, 8'h01, 8'h40, 3);
		cmd(8'h26, 8'h10, 8'h01, 8'h02, 2, 2'b01, 4, 8'h01, 8'h00, 3);
		cmd(8'h0C, 8'h10, 8'h01, 8'h02, 2, 2'b01, 4, 8'h01, 8'h00, 3);
		cmd(8'hC6, 8'h00, 8'h01, 8'h01, 2, 2'b00, 8, 8'h05, 8'h00, 2);
		wr(4'h1, 8'h1F);
		rdChk(4'h1, 8'h80);
		rdChk(4'h0, 8'h00);
		summarize;
	end
endmodule // fdcrd_core_tb
